//--- pqs_input_qualify.sv
// Input qualification, pin disqualification and frame or sync pulse alignment.
`timescale 1ns/1ps
module pqs_input_qualify #(
  parameter int NI = 4,
  parameter int NL = 2,
  parameter int NP = 4,
  parameter int NO = 4,
  parameter int TICK_CYCLES = pqs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Monitor alarms, same clock domain
  input wire logic [NI-1:0] alarm_activity,
  input wire logic [NI-1:0] alarm_loss,
  // External pins
  input wire logic [NP-1:0] dsq_pin,
  input wire logic [NI-1:0] ref_input,
  // Qualification results
  output logic [NL*NI-1:0] input_valid,
  output logic [NL-1:0] switchover_req,
  output logic osc_ref_suspect,
  // Alignment outputs
  output logic [NL-1:0] align_pulse,
  output logic [NL-1:0] locked_clock_out,
  output logic [NL-1:0] pulse_signal_out,
  output logic [NO-1:0] ref_output
);

  //--------------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [2*NI-1:0] mask;
    logic [3:0] tcfg;
    logic [NP*NI-1:0] pinmap;
    logic [NL-1:0][31:0] ctl;
    logic [NL-1:0][31:0] div;
    logic [NO-1:0][3:0] omap;
    logic [15:0] tick_cnt;
    logic tick;
    logic [NI-1:0] mon_dsq;
    logic [NI-1:0][15:0] mon_cnt;
    logic [NI-1:0] pin_dsq;
    logic [NL-1:0][NI-1:0] valid;
    logic [NL-1:0] sw_req;
    logic osc_sus;
    logic [NL-1:0][1:0] al;
    logic [NL-1:0] align;
    logic [NL-1:0][15:0] ecnt;
    logic [NL-1:0][15:0] ccnt;
    logic [NL-1:0][7:0] pwcnt;
    logic [NL-1:0] cko;
    logic [NL-1:0] pso;
    logic [NO-1:0] out;
  } pqs_state_t;

  pqs_state_t s_r;
  pqs_state_t s_nxt;
  logic [NP-1:0] pin_q;
  logic [NI-1:0] ref_q;
  logic [NI-1:0] ref_rise;
  logic [NI-1:0] ref_fall;

  //--------------------------------------------------------------------------
  // Synchronisers
  //--------------------------------------------------------------------------
  // RULE24 two-stage pin sync
  pqs_sync_edge #(.W(NP)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(dsq_pin),
    .q(pin_q),
    .rise(),
    .fall()
  );

  pqs_sync_edge #(.W(NI)) u_ref_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(ref_input),
    .q(ref_q),
    .rise(ref_rise),
    .fall(ref_fall)
  );

  //--------------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------------
  function automatic logic bit_at(input logic [15:0] v, input logic [3:0] idx);
    return v[idx];
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++) begin
      if (b[k]) begin
        r[8*k +: 8] = d[8*k +: 8];
      end
    end
    return r;
  endfunction

  // Returns the register kind in the low nibble and the loop index above it.
  function automatic logic [7:0] dec(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] rel;
    r = {4'h0, pqs_pkg::K_NONE};
    rel = a - pqs_pkg::A_LOOP;
    if (a == pqs_pkg::A_STATUS) r = {4'h0, pqs_pkg::K_STAT};
    else if (a == pqs_pkg::A_MASK) r = {4'h0, pqs_pkg::K_MASK};
    else if (a == pqs_pkg::A_TIMER) r = {4'h0, pqs_pkg::K_TIM};
    else if (a == pqs_pkg::A_PINMAP) r = {4'h0, pqs_pkg::K_PMAP};
    else if (a == pqs_pkg::A_OUTMAP) r = {4'h0, pqs_pkg::K_OMAP};
    else if (a >= pqs_pkg::A_LOOP && 32'(rel[7:4]) < NL) begin
      if (rel[3:0] == pqs_pkg::L_CTL) r = {rel[7:4], pqs_pkg::K_LCTL};
      else if (rel[3:0] == pqs_pkg::L_DIV) r = {rel[7:4], pqs_pkg::K_LDIV};
      else if (rel[3:0] == pqs_pkg::L_STAT) r = {rel[7:4], pqs_pkg::K_LSTAT};
    end
    return r;
  endfunction

  function automatic logic [15:0] dsq_ticks(input logic [1:0] c);
    case (c)
      2'h0: return pqs_pkg::DSQ_T0;
      2'h1: return pqs_pkg::DSQ_T1;
      2'h2: return pqs_pkg::DSQ_T2;
      default: return pqs_pkg::DSQ_T3;
    endcase
  endfunction

  function automatic logic [7:0] pw_cycles(input logic [1:0] c);
    case (c)
      2'h0: return pqs_pkg::PW_0;
      2'h1: return pqs_pkg::PW_1;
      2'h2: return pqs_pkg::PW_2;
      default: return pqs_pkg::PW_3;
    endcase
  endfunction

  //--------------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------------
  always_comb begin
    logic [7:0] d;
    logic [31:0] w;
    logic [15:0] dq;
    logic [15:0] qt;
    logic act;
    logic edge_hit;
    logic clk_hit;
    logic [3:0] cur;
    logic [NI-1:0] others;
    d = '0;
    w = '0;
    dq = '0;
    qt = '0;
    act = 1'b0;
    edge_hit = 1'b0;
    clk_hit = 1'b0;
    cur = '0;
    others = '0;
    s_nxt = s_r;

    // Bus write channels are taken in either order.
    if (awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.waddr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = wdata;
      s_nxt.wstrb = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_nxt.aw_got && s_nxt.w_got && !s_nxt.bvalid) begin
      d = dec(s_nxt.waddr);
      s_nxt.bresp = pqs_pkg::RESP_OK;
      case (d[3:0])
        pqs_pkg::K_MASK: begin
          w = wmerge(32'(s_r.mask), s_nxt.wdata, s_nxt.wstrb);
          s_nxt.mask = w[2*NI-1:0];
        end
        pqs_pkg::K_TIM: begin
          w = wmerge(32'(s_r.tcfg), s_nxt.wdata, s_nxt.wstrb);
          s_nxt.tcfg = w[3:0];
        end
        pqs_pkg::K_PMAP: begin
          w = wmerge(32'(s_r.pinmap), s_nxt.wdata, s_nxt.wstrb);
          s_nxt.pinmap = w[NP*NI-1:0];
        end
        pqs_pkg::K_OMAP: begin
          w = wmerge(32'(s_r.omap), s_nxt.wdata, s_nxt.wstrb);
          s_nxt.omap = w[4*NO-1:0];
        end
        pqs_pkg::K_LCTL: begin
          s_nxt.ctl[d[7:4]] = wmerge(s_r.ctl[d[7:4]], s_nxt.wdata, s_nxt.wstrb);
        end
        pqs_pkg::K_LDIV: begin
          s_nxt.div[d[7:4]] = wmerge(s_r.div[d[7:4]], s_nxt.wdata, s_nxt.wstrb);
        end
        pqs_pkg::K_STAT, pqs_pkg::K_LSTAT: begin
        end
        default: begin
          s_nxt.bresp = pqs_pkg::RESP_SLVERR;
        end
      endcase
      s_nxt.bvalid = 1'b1;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

    // Read channel answers one cycle after the address is taken.
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && s_r.arready) begin
      d = dec(araddr);
      s_nxt.rdata = '0;
      s_nxt.rresp = pqs_pkg::RESP_OK;
      case (d[3:0])
        pqs_pkg::K_STAT: begin
          s_nxt.rdata = 32'(s_r.mon_dsq) | (32'(s_r.pin_dsq) << pqs_pkg::F_PINDSQ);
          s_nxt.rdata[pqs_pkg::F_OSC] = s_r.osc_sus;
        end
        pqs_pkg::K_MASK: s_nxt.rdata = 32'(s_r.mask);
        pqs_pkg::K_TIM: s_nxt.rdata = 32'(s_r.tcfg);
        pqs_pkg::K_PMAP: s_nxt.rdata = 32'(s_r.pinmap);
        pqs_pkg::K_OMAP: s_nxt.rdata = 32'(s_r.omap);
        pqs_pkg::K_LCTL: s_nxt.rdata = s_r.ctl[d[7:4]];
        pqs_pkg::K_LDIV: s_nxt.rdata = s_r.div[d[7:4]];
        pqs_pkg::K_LSTAT: s_nxt.rdata = 32'(s_r.valid[d[7:4]]);
        default: s_nxt.rresp = pqs_pkg::RESP_SLVERR;
      endcase
      s_nxt.rvalid = 1'b1;
    end
    s_nxt.arready = !s_nxt.rvalid;

    // Base tick of 1.25 ms for the qualification timers.
    s_nxt.tick = 1'b0;
    if (32'(s_r.tick_cnt) >= TICK_CYCLES - 1) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
    end

    dq = dsq_ticks(s_r.tcfg[1:0]);
    case (s_r.tcfg[pqs_pkg::F_QUAL +: 2])
      2'h0: qt = 16'(dq << 2);
      2'h1: qt = 16'(dq << 1);
      2'h2: qt = 16'(dq << 3);
      default: qt = 16'(dq << 4);
    endcase

    for (int i = 0; i < NI; i++) begin
      act = (alarm_activity[i] & ~s_r.mask[2*i]) | (alarm_loss[i] & ~s_r.mask[2*i+1]);
      if (!s_r.mon_dsq[i]) begin
        // RULE21 disqualify on held alarm
        if (!act) begin
          s_nxt.mon_cnt[i] = '0;
        end else if (s_r.tick) begin
          if (s_r.mon_cnt[i] + 16'h0001 >= dq) begin
            s_nxt.mon_dsq[i] = 1'b1;
            s_nxt.mon_cnt[i] = '0;
          end else begin
            s_nxt.mon_cnt[i] = s_r.mon_cnt[i] + 16'h0001;
          end
        end
      end else begin
        // RULE22 requalify after clear
        if (act) begin
          s_nxt.mon_cnt[i] = '0;
        end else if (s_r.tick) begin
          if (s_r.mon_cnt[i] + 16'h0001 >= qt) begin
            s_nxt.mon_dsq[i] = 1'b0;
            s_nxt.mon_cnt[i] = '0;
          end else begin
            s_nxt.mon_cnt[i] = s_r.mon_cnt[i] + 16'h0001;
          end
        end
      end
      // RULE2 pin disqualify map
      s_nxt.pin_dsq[i] = 1'b0;
      for (int p = 0; p < NP; p++) begin
        if (pin_q[p] && s_r.pinmap[p*NI+i]) begin
          s_nxt.pin_dsq[i] = 1'b1;
        end
      end
    end

    // RULE20 all inputs failed
    s_nxt.osc_sus = &s_nxt.mon_dsq;

    for (int l = 0; l < NL; l++) begin
      // RULE1 RULE23 per-loop validity
      for (int i = 0; i < NI; i++) begin
        s_nxt.valid[l][i] = s_r.ctl[l][pqs_pkg::F_EN+i] & ~s_nxt.mon_dsq[i]
                            & ~s_nxt.pin_dsq[i];
      end
      // RULE3 switchover on pin loss
      cur = s_r.ctl[l][pqs_pkg::F_CUR +: 4];
      others = s_nxt.valid[l] & ~NI'(16'h0001 << cur);
      s_nxt.sw_req[l] = bit_at(16'(s_nxt.pin_dsq), cur) & ~bit_at(16'(s_r.pin_dsq), cur)
                        & (|others);

      // RULE19 selectable pulse and clock inputs
      // RULE5 RULE18 edge polarity
      edge_hit = s_r.ctl[l][pqs_pkg::F_FALL]
               ? bit_at(16'(ref_fall), s_r.ctl[l][pqs_pkg::F_PSEL +: 4])
               : bit_at(16'(ref_rise), s_r.ctl[l][pqs_pkg::F_PSEL +: 4]);
      clk_hit = bit_at(16'(ref_rise), s_r.ctl[l][pqs_pkg::F_CSEL +: 4]);
      s_nxt.align[l] = 1'b0;
      if (!s_r.ctl[l][pqs_pkg::F_ALIGN]) begin
        s_nxt.al[l] = pqs_pkg::AL_IDLE;
      end else if (s_r.ctl[l][pqs_pkg::F_SYNC]) begin
        // RULE13 RULE14 sync edge aligns
        s_nxt.al[l] = pqs_pkg::AL_IDLE;
        s_nxt.align[l] = edge_hit;
      end else begin
        // RULE4 RULE6 RULE10 frame arms, clock aligns
        case (s_r.al[l])
          pqs_pkg::AL_IDLE: begin
            if (edge_hit) s_nxt.al[l] = pqs_pkg::AL_ARMED;
          end
          pqs_pkg::AL_ARMED: begin
            if (clk_hit) begin
              s_nxt.align[l] = 1'b1;
              s_nxt.al[l] = edge_hit ? pqs_pkg::AL_ARMED : pqs_pkg::AL_IDLE;
            end
          end
          default: s_nxt.al[l] = pqs_pkg::AL_IDLE;
        endcase
      end

      if (s_r.pwcnt[l] != 8'h00) begin
        s_nxt.pwcnt[l] = s_r.pwcnt[l] - 8'h01;
      end
      // RULE12 outputs shift on alignment
      if (s_nxt.align[l]) begin
        s_nxt.ecnt[l] = '0;
        s_nxt.ccnt[l] = '0;
        s_nxt.cko[l] = 1'b1;
        s_nxt.pwcnt[l] = pw_cycles(s_r.ctl[l][pqs_pkg::F_PW +: 2]);
      end else if (clk_hit) begin
        // RULE9 output rates from divider
        if (s_r.ecnt[l] + 16'h0001 >= s_r.div[l][15:0]) begin
          s_nxt.ecnt[l] = '0;
          // RULE11 selectable pulse width
          s_nxt.pwcnt[l] = pw_cycles(s_r.ctl[l][pqs_pkg::F_PW +: 2]);
        end else begin
          s_nxt.ecnt[l] = s_r.ecnt[l] + 16'h0001;
        end
        if (s_r.ccnt[l] + 16'h0001 >= s_r.div[l][31:16]) begin
          s_nxt.ccnt[l] = '0;
          s_nxt.cko[l] = ~s_r.cko[l];
        end else begin
          s_nxt.ccnt[l] = s_r.ccnt[l] + 16'h0001;
        end
      end
      s_nxt.pso[l] = s_nxt.pwcnt[l] != 8'h00;
    end

    // RULE19 output routing
    for (int o = 0; o < NO; o++) begin
      s_nxt.out[o] = s_nxt.omap[o][pqs_pkg::F_OKIND]
                   ? bit_at(16'(s_nxt.pso), {2'h0, s_nxt.omap[o][1:0]})
                   : bit_at(16'(s_nxt.cko), {2'h0, s_nxt.omap[o][1:0]});
    end
  end

  //--------------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.tcfg <= pqs_pkg::TIM_RST;
      for (int l = 0; l < NL; l++) begin
        s_r.ctl[l] <= pqs_pkg::CTL_RST;
        s_r.div[l] <= pqs_pkg::DIV_RST;
        s_r.al[l] <= pqs_pkg::AL_IDLE;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rresp = s_r.rresp;
  assign rdata = s_r.rdata;
  assign input_valid = s_r.valid;
  assign switchover_req = s_r.sw_req;
  assign osc_ref_suspect = s_r.osc_sus;
  assign align_pulse = s_r.align;
  assign locked_clock_out = s_r.cko;
  assign pulse_signal_out = s_r.pso;
  assign ref_output = s_r.out;

endmodule // pqs_input_qualify

//--- pqs_input_qualify_chk.sv
// Port checker for input qualification and pulse alignment.
`timescale 1ns/1ps
module pqs_input_qualify_chk #(
  parameter int NI = 4,
  parameter int NL = 2,
  parameter int NP = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports
  input wire logic [NP-1:0] dsq_pin,
  input wire logic [NL*NI-1:0] input_valid,
  input wire logic [NL-1:0] switchover_req,
  input wire logic osc_ref_suspect,
  input wire logic [NL-1:0] align_pulse,
  input wire logic [NL-1:0] locked_clock_out,
  input wire logic [NL-1:0] pulse_signal_out,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic rvalid,
  input wire logic rready
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_switch_single: assert property (switchover_req[0] |=> !switchover_req[0])
    else $error("switchover request too long");
  a_switch_other: assert property (switchover_req[0] |-> input_valid[NI-1:0] != '0)
    else $error("switchover with no valid input left");
  a_pin_synced: assert property (switchover_req[0] |-> $past(|dsq_pin, 2))
    else $error("switchover without an earlier pin");
  a_suspect_all: assert property (osc_ref_suspect && $past(osc_ref_suspect) |-> input_valid == '0)
    else $error("suspect oscillator with valid inputs");
  a_align_outs: assert property (align_pulse[0] |-> pulse_signal_out[0] && locked_clock_out[0])
    else $error("outputs not restarted on alignment");
  a_align_single: assert property (align_pulse[0] |=> !align_pulse[0])
    else $error("alignment pulse too long");
  a_write_done: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not retired");
  a_read_done: assert property (rvalid && rready |=> !rvalid)
    else $error("read data not retired");
  c_switch: cover property (switchover_req[0]);
  c_align: cover property (align_pulse[0]);
  c_drop: cover property ($fell(input_valid[1]));
endmodule // pqs_input_qualify_chk

bind pqs_input_qualify pqs_input_qualify_chk #(.NI(NI), .NL(NL), .NP(NP)) u_chk (.*);

//--- pqs_pkg.sv
// Shared constants and types for the input qualification and pulse alignment block.
//----------------------------------------------------------------------------
// Behaviour
// RULE1 - Input valid per loop only if no unmasked alarm and no disqualify pin; code keeps it valid until the alarm is held a whole disqualify period.
// RULE2 - An asserted disqualify pin removes its mapped inputs as lock targets.
// RULE3 - Pin loss of the used input requests switchover if another valid exists.
// RULE4 - Frame mode: active pulse edge marks next associated clock rise as alignment.
// RULE5 - Frame active edge is rising by default; a setting selects falling.
// RULE6 - Frame inputs from even-second pulse up to 8kHz, paired with a clock.
// RULE7 - Frame pulse source keeps each pulse active at least 10 ns.
// RULE8 - Frame mode associated clock at most 150MHz, integer multiple of pulse.
// RULE9 - Output pulse rate programmable apart; output clock and pulse integer related.
// RULE10 - Loop outputs align to first associated clock rise after its frame pulse.
// RULE11 - Several selectable widths for the generated output pulse.
// RULE12 - With alignment enabled, outputs shift to the loop's selected input clock.
// RULE13 - Sync mode: the sync pulse edge itself is the alignment edge.
// RULE14 - Sync inputs from even-second pulse up to 8kHz align sync and clock outputs.
// RULE15 - Sync pulse source keeps each pulse active at least 10 ns.
// RULE16 - Sync mode associated clock at most 1GHz, integer multiple of pulse.
// RULE17 - Software picks sync output rates integer related to the sync input.
// RULE18 - Sync mode aligns to rising pulse edge by default; setting selects falling.
// RULE19 - Any input may be pulse or clock input, any output pulse or clock.
// RULE20 - Oscillator input unmonitored; failure inferred when all inputs fail together.
// RULE21 - Unmasked alarm held for the whole disqualify period disqualifies the input.
// RULE22 - Requalify after alarms stay clear 2, 4, 8 or 16 disqualify periods.
// RULE23 - Validity per loop and input updates synchronously on the system clock.
// RULE24 - Disqualify pins pass two flip-flops before affecting validity.
//----------------------------------------------------------------------------
package pqs_pkg;

  //--------------------------------------------------------------------------
  // Timing
  //--------------------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int TICK_NS = 1250000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;

  //--------------------------------------------------------------------------
  // Register offsets and decode kinds
  //--------------------------------------------------------------------------
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_MASK = 8'h04;
  localparam logic [7:0] A_TIMER = 8'h08;
  localparam logic [7:0] A_PINMAP = 8'h0C;
  localparam logic [7:0] A_LOOP = 8'h10;
  localparam logic [7:0] A_OUTMAP = 8'h40;
  localparam logic [3:0] L_CTL = 4'h0;
  localparam logic [3:0] L_DIV = 4'h4;
  localparam logic [3:0] L_STAT = 4'h8;
  localparam logic [3:0] K_NONE = 4'h0;
  localparam logic [3:0] K_STAT = 4'h1;
  localparam logic [3:0] K_MASK = 4'h2;
  localparam logic [3:0] K_TIM = 4'h3;
  localparam logic [3:0] K_PMAP = 4'h4;
  localparam logic [3:0] K_OMAP = 4'h5;
  localparam logic [3:0] K_LCTL = 4'h6;
  localparam logic [3:0] K_LDIV = 4'h7;
  localparam logic [3:0] K_LSTAT = 4'h8;

  //--------------------------------------------------------------------------
  // Field positions and reset values
  //--------------------------------------------------------------------------
  localparam int F_PSEL = 0;
  localparam int F_CSEL = 4;
  localparam int F_SYNC = 8;
  localparam int F_FALL = 9;
  localparam int F_ALIGN = 10;
  localparam int F_PW = 12;
  localparam int F_CUR = 16;
  localparam int F_EN = 24;
  localparam int F_PINDSQ = 8;
  localparam int F_OSC = 31;
  localparam int F_QUAL = 2;
  localparam int F_OKIND = 2;
  localparam logic [31:0] CTL_RST = 32'hFF00_0000;
  localparam logic [31:0] DIV_RST = 32'h0001_0004;
  localparam logic [3:0] TIM_RST = 4'h0;

  //--------------------------------------------------------------------------
  // Timer tables in 1.25 ms ticks, pulse widths in system clocks
  //--------------------------------------------------------------------------
  localparam logic [15:0] DSQ_T0 = 16'h07D0;
  localparam logic [15:0] DSQ_T1 = 16'h0001;
  localparam logic [15:0] DSQ_T2 = 16'h0014;
  localparam logic [15:0] DSQ_T3 = 16'h0028;
  localparam logic [7:0] PW_0 = 8'h01;
  localparam logic [7:0] PW_1 = 8'h04;
  localparam logic [7:0] PW_2 = 8'h10;
  localparam logic [7:0] PW_3 = 8'h40;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    AL_IDLE = 2'b01,
    AL_ARMED = 2'b10
  } pqs_align_t;

endpackage

//--- pqs_src_model.sv
// Far-side sources: reference and pulse pins, link clock and disqualify pins.
`timescale 1ns/1ps
module pqs_src_model (
  // Clock and associated clock gate
  input wire logic aclk,
  input wire logic clk_on,
  // Pins toward the block
  output logic [3:0] ref_input,
  output logic [3:0] dsq_pin
);
  initial begin
    ref_input = 4'h0;
    dsq_pin = 4'h0;
  end
  // slow associated clock
  // The clock stands still between frames, so no stray rise can arm a shift.
  always #160 begin
    if (clk_on) begin
      ref_input[1] = ~ref_input[1];
    end
  end
  task automatic drv_ref(input int i, input logic v);
    @(posedge aclk);
    ref_input[i] <= v;
  endtask
  task automatic drv_pin(input int p, input logic v);
    @(posedge aclk);
    dsq_pin[p] <= v;
  endtask
endmodule // pqs_src_model

//--- pqs_sync_edge.sv
// Two-stage pin synchroniser with edge detection on the settled copy.
`timescale 1ns/1ps
module pqs_sync_edge #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous inputs
  input wire logic [W-1:0] d,
  // Synchronised level and edges
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Only the second and third stages feed logic, never the first.
  assign q = s2_r;
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
endmodule // pqs_sync_edge

//--- testbench.sv
// Self-checking bench for input qualification and pulse alignment.
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0, clk_on = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF, alarm_activity = 4'h0, alarm_loss = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, osc_ref_suspect;
  logic [1:0] bresp, rresp, switchover_req, align_pulse, locked_clock_out, pulse_signal_out;
  logic [31:0] rdata;
  logic [7:0] input_valid;
  logic [3:0] ref_input, dsq_pin, ref_output;
  int fails = 0;
  int samples_checked = 0;
  always #20 aclk = ~aclk;
  pqs_input_qualify #(.TICK_CYCLES(4)) dut (.*);
  pqs_src_model src (.aclk(aclk), .clk_on(clk_on), .ref_input(ref_input), .dsq_pin(dsq_pin));
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  task automatic watch(input int n, output int first, output int hi, output int ro);
    first = -1;
    hi = 0;
    ro = 0;
    for (int k = 0; k < n; k++) begin
      @(posedge aclk);
      if (align_pulse[0] === 1'b1 && first < 0) first = k;
      if (pulse_signal_out[0] === 1'b1) hi++;
      if (ref_output[0] === 1'b1) ro++;
    end
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h10, d, r);
    chk(d === pqs_pkg::CTL_RST, "control reset value");
    rd(8'h14, d, r);
    chk(d === pqs_pkg::DIV_RST, "divider reset value");
    rd(8'h30, d, r);
    chk(r === pqs_pkg::RESP_SLVERR && d === 32'h0, "unmapped read");
    $display("test regs done");
  endtask
  task automatic t_pin();
    int n;
    wr(pqs_pkg::A_PINMAP, 32'h2);
    wr(pqs_pkg::A_LOOP, 32'hFF01_0000);
    chk(input_valid[1] === 1'b1, "input valid before pin");
    src.drv_pin(0, 1'b1);
    for (n = 0; n < 10 && switchover_req[0] !== 1'b1; n++) @(posedge aclk);
    chk(switchover_req[0] === 1'b1, "switchover on pin");
    chk(n >= 2, "pin seen too early");
    @(posedge aclk);
    chk(input_valid[1] === 1'b0 && input_valid[5] === 1'b0, "pin keeps input");
    chk(input_valid[2] === 1'b1, "other input lost");
    src.drv_pin(0, 1'b0);
    $display("test pin done");
  endtask
  task automatic t_alarm();
    logic [31:0] d;
    logic [1:0] r;
    wr(pqs_pkg::A_TIMER, 32'h1);
    wr(pqs_pkg::A_MASK, 32'hFF);
    // Activity alarms on inputs 0 and 1, loss alarms on inputs 2 and 3.
    {alarm_activity, alarm_loss} <= 8'h3C;
    repeat (20) @(posedge aclk);
    chk(input_valid === 8'hFF && osc_ref_suspect === 1'b0, "masked alarm counted");
    wr(pqs_pkg::A_MASK, 32'h0);
    repeat (20) @(posedge aclk);
    chk(input_valid === 8'h00, "alarm ignored");
    chk(osc_ref_suspect === 1'b1, "all inputs lost, oscillator not suspect");
    rd(pqs_pkg::A_STATUS, d, r);
    chk(d === 32'h8000_000F && r === pqs_pkg::RESP_OK, "status after loss");
    {alarm_activity, alarm_loss} <= 8'h00;
    repeat (8) @(posedge aclk);
    chk(input_valid === 8'h00, "requalified too soon");
    repeat (30) @(posedge aclk);
    chk(input_valid === 8'hFF && osc_ref_suspect === 1'b0, "not requalified");
    $display("test alarm done");
  endtask
  task automatic t_align();
    int f, h, o;
    wr(pqs_pkg::A_OUTMAP, 32'h4);
    wr(pqs_pkg::A_LOOP, 32'hFF01_1500);
    src.drv_ref(0, 1'b1);
    watch(12, f, h, o);
    chk(f >= 0 && h == 4 && o == 4, "sync shift or width");
    src.drv_ref(0, 1'b0);
    // The falling edge must pass first, or falling-edge frame mode would arm on it.
    repeat (4) @(posedge aclk);
    wr(pqs_pkg::A_LOOP, 32'hFF01_0610);
    clk_on <= 1'b1;
    src.drv_ref(0, 1'b1);
    watch(20, f, h, o);
    chk(f < 0, "shift on rising edge");
    src.drv_ref(0, 1'b0);
    watch(20, f, h, o);
    chk(f >= 0, "no shift after falling edge");
    clk_on <= 1'b0;
    $display("test align done");
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_pin();
    t_alarm();
    t_align();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    close_out();
  end
endmodule // testbench
